// *** rtl/tgm_defs.svh ***
// Constants shared by both ends of the ten gig MAC link
//--------------------------------------------------------------------
//--------------------------------------------------------------------
`ifndef TGM_DEFS_SVH
`define TGM_DEFS_SVH

// Register byte offsets
`define TGM_A_CFG      12'h000
`define TGM_A_STAT     12'h004
`define TGM_A_DIV      12'h008
`define TGM_A_CMD      12'h00c
`define TGM_A_RD       12'h010
`define TGM_CFG_RST    32'h00000003
`define TGM_CMD_RST    32'h00000000
`define TGM_DIV_RST    8'h00
// Field positions
`define TGM_B_TXEN     0
`define TGM_B_RXEN     1
`define TGM_B_TXRST    2
`define TGM_B_RXRST    3
`define TGM_B_DIC      4
`define TGM_F_DIV      7:0
`define TGM_F_WDATA    15:0
`define TGM_F_REGAD    20:16
`define TGM_F_PHYAD    25:21
`define TGM_B_RD       26
// Serial management timing
`define TGM_PCLK_KHZ   10000
`define TGM_MDC_KHZ    2500
`define TGM_MDC_HALF   ((`TGM_PCLK_KHZ + 2 * `TGM_MDC_KHZ - 1) / (2 * `TGM_MDC_KHZ))
`define TGM_MD_PRE     32'hffffffff
`define TGM_MD_ST      2'b01
`define TGM_MD_OPW     2'b01
`define TGM_MD_OPR     2'b10
`define TGM_MD_TA      2'b10
`define TGM_MD_PRELEN  6'h20
`define TGM_MD_HDREND  6'h2d
`define TGM_MD_TAPOS   6'h2e
`define TGM_MD_TA2     6'h2f
`define TGM_MD_DPOS    6'h30
`define TGM_MD_LAST    6'h3f
`define TGM_PHY_RST    16'h1234
// Media words and control lanes
`define TGM_IDLE_WORD  64'h0707070707070707
`define TGM_START_WORD 64'hd5555555555555fb
`define TGM_TERM_WORD  64'h07070707070707fd
`define TGM_ERR_WORD   64'hfefefefefefefefe
`define TGM_START_CH   8'hfb
`define TGM_TERM_CH    8'hfd
`define TGM_LF_SEQ     32'h0100009c
`define TGM_RF_SEQ     32'h0200009c
`define TGM_CTL_ALL    8'hff
`define TGM_CTL_NONE   8'h00
`define TGM_CTL_START  8'h01
`define TGM_CTL_SEQ    8'h11
`define TGM_GAP_WORDS  1'b1
`define TGM_FLT_CLR    7'h7f

`endif

// *** rtl/tgm_if.sv ***
// Media link between the MAC end and the PHY end
`timescale 1ns/1ns
`default_nettype none

interface tgm_if;
  logic [63:0] txd;
  logic [7:0]  txc;
  logic [63:0] rxd;
  logic [7:0]  rxc;
  logic        mdc;
  logic        mdio_m_o;
  logic        mdio_m_oe_n;
  logic        mdio_p_o;
  logic        mdio_p_oe_n;
  logic        mdio_line;

  // Open drain wire with pull-up
  assign mdio_line = (mdio_m_oe_n | mdio_m_o) & (mdio_p_oe_n | mdio_p_o);

  modport mac (output txd, txc, mdc, mdio_m_o, mdio_m_oe_n,
               input  rxd, rxc, mdio_line);
  modport phy (input  txd, txc, mdc, mdio_line,
               output rxd, rxc, mdio_p_o, mdio_p_oe_n);
endinterface : tgm_if

`default_nettype wire

// *** rtl/tgm_mac_end.sv ***
// MAC end: APB registers, transmit, receive and link fault handling
//
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "tgm_defs.svh"

module tgm_mac_end
  import tgm_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_locked,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [63:0] tx_tdata,
  input  wire logic        tx_tvalid,
  input  wire logic        tx_tlast,
  output logic             tx_tready,
  output logic [63:0]      rx_tdata,
  output logic             rx_tvalid,
  output logic             rx_tlast,
  output logic             rx_tuser,
  tgm_if.mac               xg
);
  logic [31:0]   cfg;
  logic [7:0]    div;
  logic [31:0]   cmd;
  logic          md_start;
  logic          md_busy;
  logic [15:0]   md_rdata;
  tgm_fault_e    fault;
  logic [6:0]    flt_cnt;
  tgm_tx_state_e tx_state;
  logic          gap_cnt;
  logic          deficit;
  logic [63:0]   fill_d;
  logic [7:0]    fill_c;
  logic [63:0]   hold;
  logic          hold_ok;
  logic          in_frame;
  logic          rx_err;
  logic          tx_run;
  logic          rx_run;
  logic          wr_en;

  function automatic logic is_seq(input logic [63:0] d, input logic [7:0] c,
                                  input logic [31:0] s);
    is_seq = c == `TGM_CTL_SEQ && d[31:0] == s;
  endfunction : is_seq

  function automatic logic mapped(input logic [11:0] a);
    mapped = a == `TGM_A_CFG || a == `TGM_A_STAT || a == `TGM_A_DIV ||
             a == `TGM_A_CMD || a == `TGM_A_RD;
  endfunction : mapped

  // Lock low acts as a synchronous reset on the whole datapath
  assign tx_run = clk_locked && cfg[`TGM_B_TXEN] && !cfg[`TGM_B_TXRST];
  assign rx_run = clk_locked && cfg[`TGM_B_RXEN] && !cfg[`TGM_B_RXRST];
  assign wr_en  = psel && penable && pready && pwrite;

  //--------------------------------------------------------------------
  // APB slave, no wait state on any transfer
  //--------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable && !pready;
      if (psel && !penable) begin
        pslverr <= !mapped(paddr);
        unique case (paddr)
          `TGM_A_CFG:  prdata <= cfg;
          `TGM_A_STAT: prdata <= {28'h0000000, md_busy, clk_locked,
                                  fault == FLT_REMOTE, fault == FLT_LOCAL};
          `TGM_A_DIV:  prdata <= {24'h000000, div};
          `TGM_A_CMD:  prdata <= cmd;
          `TGM_A_RD:   prdata <= {15'h0000, md_busy, md_rdata};
          default:     prdata <= 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg      <= `TGM_CFG_RST;
      div      <= `TGM_DIV_RST;
      cmd      <= `TGM_CMD_RST;
      md_start <= 1'b0;
    end else begin
      md_start <= 1'b0;
      if (wr_en && paddr == `TGM_A_CFG) cfg <= pwdata;
      if (wr_en && paddr == `TGM_A_DIV) div <= pwdata[`TGM_F_DIV];
      // A command while busy or before the divisor is set is dropped
      if (wr_en && paddr == `TGM_A_CMD && !md_busy) begin
        cmd      <= pwdata;
        md_start <= div != `TGM_DIV_RST;
      end
    end
  end

  tgm_mdio u_mdio (
    .pclk      (pclk),
    .presetn   (presetn),
    .div       (div),
    .start     (md_start),
    .rd        (cmd[`TGM_B_RD]),
    .phyad     (cmd[`TGM_F_PHYAD]),
    .regad     (cmd[`TGM_F_REGAD]),
    .wdata     (cmd[`TGM_F_WDATA]),
    .mdio_i    (xg.mdio_line),
    .busy      (md_busy),
    .rdata     (md_rdata),
    .mdc       (xg.mdc),
    .mdio_o    (xg.mdio_m_o),
    .mdio_oe_n (xg.mdio_m_oe_n)
  );

  //--------------------------------------------------------------------
  // Link fault tracking
  //--------------------------------------------------------------------
  // A fault clears after a run of words free of fault sets, or at once while lock is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault   <= FLT_NONE;
      flt_cnt <= 7'h00;
    end else if (!clk_locked) begin
      fault   <= FLT_NONE;
      flt_cnt <= 7'h00;
    end else if (is_seq(xg.rxd, xg.rxc, `TGM_LF_SEQ)) begin
      fault   <= FLT_LOCAL;
      flt_cnt <= 7'h00;
    end else if (is_seq(xg.rxd, xg.rxc, `TGM_RF_SEQ)) begin
      fault   <= FLT_REMOTE;
      flt_cnt <= 7'h00;
    end else if (flt_cnt == `TGM_FLT_CLR) begin
      fault <= FLT_NONE;
    end else begin
      flt_cnt <= flt_cnt + 7'h01;
    end
  end

  always_comb begin
    fill_d = `TGM_IDLE_WORD;
    fill_c = `TGM_CTL_ALL;
    if (fault == FLT_LOCAL) begin
      fill_d = {`TGM_RF_SEQ, `TGM_RF_SEQ};
      fill_c = `TGM_CTL_SEQ;
    end
  end

  //--------------------------------------------------------------------
  // Transmit
  //--------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state  <= TX_IDLE;
      tx_tready <= 1'b0;
      xg.txd    <= `TGM_IDLE_WORD;
      xg.txc    <= `TGM_CTL_ALL;
      gap_cnt   <= 1'b0;
      deficit   <= 1'b0;
    end else if (!tx_run) begin
      tx_state  <= TX_IDLE;
      tx_tready <= 1'b0;
      xg.txd    <= `TGM_IDLE_WORD;
      xg.txc    <= `TGM_CTL_ALL;
      gap_cnt   <= 1'b0;
      deficit   <= 1'b0;
    end else begin
      unique case (tx_state)
        TX_DATA, TX_DROP: begin
          if (tx_state == TX_DATA && fault == FLT_NONE) begin
            xg.txd <= tx_tvalid ? tx_tdata : `TGM_ERR_WORD;
            xg.txc <= tx_tvalid ? `TGM_CTL_NONE : `TGM_CTL_ALL;
          end else begin
            xg.txd   <= fill_d;
            xg.txc   <= fill_c;
            tx_state <= TX_DROP;
          end
          if (tx_tvalid && tx_tlast) begin
            tx_tready <= 1'b0;
            gap_cnt   <= 1'b0;
            tx_state  <= (tx_state == TX_DATA && fault == FLT_NONE) ? TX_TERM : TX_GAP;
          end
        end
        TX_TERM: begin
          xg.txd   <= `TGM_TERM_WORD;
          xg.txc   <= `TGM_CTL_ALL;
          // Deficit mode skips the extra idle word on every other frame
          gap_cnt  <= (cfg[`TGM_B_DIC] && deficit) ? 1'b0 : `TGM_GAP_WORDS;
          deficit  <= cfg[`TGM_B_DIC] && !deficit;
          tx_state <= TX_GAP;
        end
        TX_IDLE, TX_GAP: begin
          xg.txd <= fill_d;
          xg.txc <= fill_c;
          if (tx_state == TX_GAP && gap_cnt) begin
            gap_cnt <= 1'b0;
          end else if (tx_tvalid) begin
            // Starts straight out of the gap so queued frames lose no word
            tx_tready <= 1'b1;
            if (fault == FLT_NONE) begin
              xg.txd   <= `TGM_START_WORD;
              xg.txc   <= `TGM_CTL_START;
              tx_state <= TX_DATA;
            end else begin
              tx_state <= TX_DROP;
            end
          end else begin
            tx_state <= TX_IDLE;
          end
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

  //--------------------------------------------------------------------
  // Receive, one word held back to mark the last beat
  //--------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_tdata  <= 64'h0;
      rx_tvalid <= 1'b0;
      rx_tlast  <= 1'b0;
      rx_tuser  <= 1'b0;
      hold      <= 64'h0;
      hold_ok   <= 1'b0;
      in_frame  <= 1'b0;
      rx_err    <= 1'b0;
    end else begin
      rx_tvalid <= 1'b0;
      rx_tlast  <= 1'b0;
      rx_tuser  <= 1'b0;
      if (!rx_run) begin
        in_frame <= 1'b0;
        hold_ok  <= 1'b0;
      end else if (xg.rxc == `TGM_CTL_START && xg.rxd[7:0] == `TGM_START_CH) begin
        in_frame <= 1'b1;
        hold_ok  <= 1'b0;
        rx_err   <= 1'b0;
      end else if (in_frame) begin
        if (xg.rxc == `TGM_CTL_NONE) begin
          rx_tdata  <= hold;
          rx_tvalid <= hold_ok;
          hold      <= xg.rxd;
          hold_ok   <= 1'b1;
        end else if (xg.rxc[0] && xg.rxd[7:0] == `TGM_TERM_CH) begin
          in_frame  <= 1'b0;
          hold_ok   <= 1'b0;
          rx_tdata  <= hold;
          rx_tvalid <= hold_ok;
          rx_tlast  <= hold_ok;
          rx_tuser  <= hold_ok && rx_err;
        end else begin
          rx_err <= 1'b1;
        end
      end
    end
  end
endmodule : tgm_mac_end

`default_nettype wire

// *** rtl/tgm_mdio.sv ***
// Serial management master with divided clock
`timescale 1ns/1ns
`default_nettype none
`include "tgm_defs.svh"

module tgm_mdio (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  div,
  input  wire logic        start,
  input  wire logic        rd,
  input  wire logic [4:0]  phyad,
  input  wire logic [4:0]  regad,
  input  wire logic [15:0] wdata,
  input  wire logic        mdio_i,
  output logic             busy,
  output logic [15:0]      rdata,
  output logic             mdc,
  output logic             mdio_o,
  output logic             mdio_oe_n
);
  logic [8:0]  cnt;
  logic [8:0]  half;
  logic [63:0] sh;
  logic [5:0]  bitn;
  logic        op_rd;

  // Clamp keeps the serial clock at or below its ceiling for any divisor
  always_comb begin
    half = {1'b0, div} + 9'h001;
    if (half < 9'(`TGM_MDC_HALF)) half = 9'(`TGM_MDC_HALF);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy      <= 1'b0;
      rdata     <= 16'h0000;
      mdc       <= 1'b0;
      mdio_o    <= 1'b1;
      mdio_oe_n <= 1'b1;
      cnt       <= 9'h000;
      sh        <= 64'h0;
      bitn      <= 6'h00;
      op_rd     <= 1'b0;
    end else if (!busy) begin
      mdc <= 1'b0;
      cnt <= 9'h000;
      if (start && div != `TGM_DIV_RST) begin
        busy      <= 1'b1;
        op_rd     <= rd;
        bitn      <= 6'h00;
        mdio_oe_n <= 1'b0;
        mdio_o    <= 1'b1;
        sh        <= {`TGM_MD_PRE, `TGM_MD_ST, rd ? `TGM_MD_OPR : `TGM_MD_OPW,
                      phyad, regad, `TGM_MD_TA, wdata} << 1;
      end
    end else if (cnt == half - 9'h001) begin
      cnt <= 9'h000;
      mdc <= ~mdc;
      if (!mdc) begin
        if (op_rd && bitn >= `TGM_MD_DPOS) rdata <= {rdata[14:0], mdio_i};
      end else if (bitn == `TGM_MD_LAST) begin
        busy      <= 1'b0;
        mdio_oe_n <= 1'b1;
      end else begin
        bitn      <= bitn + 6'h01;
        mdio_o    <= sh[63];
        sh        <= sh << 1;
        // Release the line from turnaround on for reads
        mdio_oe_n <= op_rd && (bitn + 6'h01) >= `TGM_MD_TAPOS;
      end
    end else begin
      cnt <= cnt + 9'h001;
    end
  end
endmodule : tgm_mdio

`default_nettype wire

// *** rtl/tgm_phy_end.sv ***
// PHY end: fault injection, loopback and serial management target
`timescale 1ns/1ns
`default_nettype none
`include "tgm_defs.svh"

module tgm_phy_end
  import tgm_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [4:0] phyad,
  input  wire logic       inject_local,
  input  wire logic       inject_remote,
  tgm_if.phy              xg
);
  logic [15:0] regs [4];
  logic        mdc_q;
  logic [5:0]  ones;
  logic        active;
  logic [5:0]  pos;
  logic [12:0] hdr;
  logic [15:0] dsh;
  logic        hit;

  assign hit = hdr[9:5] == phyad;

  //--------------------------------------------------------------------
  // Receive side toward the MAC
  //--------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xg.rxd <= `TGM_IDLE_WORD;
      xg.rxc <= `TGM_CTL_ALL;
    end else if (inject_local) begin
      xg.rxd <= {`TGM_LF_SEQ, `TGM_LF_SEQ};
      xg.rxc <= `TGM_CTL_SEQ;
    end else if (inject_remote) begin
      xg.rxd <= {`TGM_RF_SEQ, `TGM_RF_SEQ};
      xg.rxc <= `TGM_CTL_SEQ;
    end else begin
      xg.rxd <= xg.txd;
      xg.rxc <= xg.txc;
    end
  end

  //--------------------------------------------------------------------
  // Serial management target
  //--------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mdc_q          <= 1'b0;
      ones           <= 6'h00;
      active         <= 1'b0;
      pos            <= 6'h00;
      hdr            <= 13'h0000;
      dsh            <= 16'h0000;
      xg.mdio_p_o    <= 1'b1;
      xg.mdio_p_oe_n <= 1'b1;
      for (int i = 0; i < 4; i++) regs[i] <= `TGM_PHY_RST;
    end else begin
      mdc_q <= xg.mdc;
      if (xg.mdc && !mdc_q) begin
        if (!active) begin
          ones <= xg.mdio_line ? (ones == `TGM_MD_PRELEN ? ones : ones + 6'h01) : 6'h00;
          if (!xg.mdio_line && ones == `TGM_MD_PRELEN) begin
            active <= 1'b1;
            pos    <= `TGM_MD_PRELEN + 6'h01;
          end
        end else begin
          pos <= pos + 6'h01;
          if (pos <= `TGM_MD_HDREND) hdr <= {hdr[11:0], xg.mdio_line};
          if (pos == `TGM_MD_TAPOS) dsh <= regs[hdr[1:0]];
          if (pos >= `TGM_MD_DPOS && hdr[11:10] == `TGM_MD_OPW)
            dsh <= {dsh[14:0], xg.mdio_line};
          if (pos == `TGM_MD_LAST) begin
            active <= 1'b0;
            ones   <= 6'h00;
            // Only the addressed PHY takes the write
            if (hdr[11:10] == `TGM_MD_OPW && hit)
              regs[hdr[1:0]] <= {dsh[14:0], xg.mdio_line};
          end
        end
      end else if (!xg.mdc && mdc_q) begin
        if (active && hdr[11:10] == `TGM_MD_OPR && hit && pos >= `TGM_MD_TA2) begin
          xg.mdio_p_oe_n <= 1'b0;
          xg.mdio_p_o    <= pos == `TGM_MD_TA2 ? 1'b0 : dsh[15];
          if (pos != `TGM_MD_TA2) dsh <= dsh << 1;
        end else begin
          xg.mdio_p_oe_n <= 1'b1;
          xg.mdio_p_o    <= 1'b1;
        end
      end
    end
  end
endmodule : tgm_phy_end

`default_nettype wire

// *** rtl/tgm_pkg.sv ***
// Types shared by both ends of the ten gig MAC link
package tgm_pkg;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_DATA = 3'b001,
    TX_TERM = 3'b010,
    TX_GAP  = 3'b011,
    TX_DROP = 3'b100
  } tgm_tx_state_e;

  typedef enum logic [1:0] {
    FLT_NONE   = 2'b00,
    FLT_LOCAL  = 2'b01,
    FLT_REMOTE = 2'b10
  } tgm_fault_e;

endpackage : tgm_pkg

// *** verification/tb_ten_gig_mac_fault_and_mgmt.sv ***
// Self-checking bench for the MAC end and PHY end joined back to back
`timescale 1ns/1ns
`default_nettype none
`include "tgm_defs.svh"

module tb_ten_gig_mac_fault_and_mgmt
  import tgm_pkg::*;
;
  logic        pclk = 1'b0, presetn = 1'b0, clk_locked = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [63:0] tx_tdata = 64'h0, rx_tdata;
  logic        tx_tvalid = 1'b0, tx_tlast = 1'b0, tx_tready, rx_tvalid, rx_tlast, rx_tuser;
  logic [4:0]  phyad = 5'h00;
  logic        inject_local = 1'b0, inject_remote = 1'b0, mdc_q = 1'b0, gap_on = 1'b0;
  logic [15:0] d;
  logic [31:0] cfg_v[3] = '{32'h2, 32'h7, 32'h3};
  logic [63:0] expq[$], rxq[$];
  logic        userq[$];
  int          gapq[$];
  int          fail_count = 0, n_tests = 0, cycles = 0, mdc_edges = 0, gap_cnt = 0, i;
  integer      seed = 32'ha8519b05;

  tgm_if xg_if ();
  tgm_mac_end tgm_mac_end_inst (.pclk(pclk), .presetn(presetn), .clk_locked(clk_locked),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_tdata(tx_tdata),
    .tx_tvalid(tx_tvalid), .tx_tlast(tx_tlast), .tx_tready(tx_tready), .rx_tdata(rx_tdata),
    .rx_tvalid(rx_tvalid), .rx_tlast(rx_tlast), .rx_tuser(rx_tuser), .xg(xg_if.mac));
  tgm_phy_end tgm_phy_end_inst (.pclk(pclk), .presetn(presetn), .phyad(phyad),
    .inject_local(inject_local), .inject_remote(inject_remote), .xg(xg_if.phy));
  tgm_link_monitor tgm_link_monitor_inst (.pclk(pclk), .presetn(presetn), .txd(xg_if.txd),
    .txc(xg_if.txc), .rxd(xg_if.rxd), .rxc(xg_if.rxc), .mdc(xg_if.mdc),
    .mdio_m_oe_n(xg_if.mdio_m_oe_n));

  always #50 pclk = ~pclk;

  //--------------------------------------------------------------------
  // Tasks
  //--------------------------------------------------------------------
  task automatic stop_test;
    $display("fail_count=%0d n_tests=%0d", fail_count, n_tests);
    if (fail_count == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t value %h expected %h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_word(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t rx word %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  // Each call waits one edge first, so psel is never driven twice in one step
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] wd);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // tvalid stays high at the end so consecutive calls form back-to-back frames
  task automatic send_frame(input int n, input int gap_at);
    int k;
    @(posedge pclk);
    for (k = 0; k < n; k++) begin
      if (k == gap_at) begin
        tx_tvalid <= 1'b0;
        @(posedge pclk);
      end
      tx_tvalid <= 1'b1;
      tx_tdata  <= {$random(seed), $random(seed)};
      tx_tlast  <= (k == n - 1);
      @(posedge pclk);
      while (tx_tready !== 1'b1) @(posedge pclk);
      expq.push_back(tx_tdata);
    end
  endtask : send_frame

  task automatic tx_end;
    @(posedge pclk);
    tx_tvalid <= 1'b0;
    tx_tlast  <= 1'b0;
  endtask : tx_end

  task automatic check_rx(input int nf, input logic bad);
    int k;
    for (k = 0; k < 300 && (k < 40 || userq.size() < nf); k++) @(posedge pclk);
    chk_reg(userq.size(), nf);
    while (userq.size() > 0) chk_reg({31'h0, userq.pop_front()}, {31'h0, bad});
    if (!bad) chk_reg(rxq.size(), (nf == 0) ? 0 : expq.size());
    while (!bad && nf > 0 && rxq.size() > 0 && expq.size() > 0) begin
      chk_word(rxq.pop_front(), expq.pop_front());
    end
    expq.delete();
    rxq.delete();
  endtask : check_rx

  task automatic probe_tready;
    int k, c;
    @(posedge pclk);
    tx_tvalid <= 1'b1;
    c = 0;
    for (k = 0; k < 50; k++) begin
      @(posedge pclk);
      if (tx_tready === 1'b1) c++;
    end
    tx_tvalid <= 1'b0;
    chk_reg(c, 0);
  endtask : probe_tready

  // Polls busy through the read register; a serial access takes about 260 cycles
  task automatic mdio(input logic [31:0] cmd);
    int k;
    apb(`TGM_A_CMD, 1'b1, cmd);
    for (k = 0; k < 400; k++) begin
      apb(`TGM_A_RD, 1'b0, 32'h0);
      if (rd[16] === 1'b0) break;
    end
  endtask : mdio

  //--------------------------------------------------------------------
  // Watchers
  //--------------------------------------------------------------------
  always @(posedge pclk) begin
    if (rx_tvalid === 1'b1) rxq.push_back(rx_tdata);
    if (rx_tvalid === 1'b1 && rx_tlast === 1'b1) userq.push_back(rx_tuser);
    if (xg_if.mdc !== mdc_q) mdc_edges++;
    mdc_q = xg_if.mdc;
    // Long idle stretches between test phases are not gaps
    if (xg_if.txc === `TGM_CTL_START) begin
      if (gap_on && gap_cnt < 8) gapq.push_back(gap_cnt);
      gap_on = 1'b0;
    end else if (xg_if.txd === `TGM_TERM_WORD) begin
      gap_on  = 1'b1;
      gap_cnt = 0;
    end else if (xg_if.txd === `TGM_IDLE_WORD) begin
      gap_cnt++;
    end
  end

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      stop_test();
    end
  end

  //--------------------------------------------------------------------
  // Main sequence
  //--------------------------------------------------------------------
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    phyad   <= 5'($random(seed));
    apb(`TGM_A_CFG, 1'b0, 32'h0);
    chk_reg(rd, `TGM_CFG_RST);
    apb(`TGM_A_STAT, 1'b0, 32'h0);
    chk_reg(rd, 32'h4);
    apb(12'h020, 1'b0, 32'h0);
    chk_reg({rd[30:0], err}, 32'h1);
    apb(`TGM_A_CMD, 1'b1, 32'h0);
    mdc_edges = 0;
    repeat (200) @(posedge pclk);
    chk_reg(mdc_edges, 0);
    apb(`TGM_A_RD, 1'b0, 32'h0);
    chk_reg({31'h0, rd[16]}, 32'h0);
    for (i = 0; i < 3; i++) begin
      send_frame(2 + $unsigned($random(seed)) % 8, -1);
      tx_end();
      check_rx(1, 1'b0);
    end
    send_frame(5, 2);
    tx_end();
    check_rx(1, 1'b1);
    gapq.delete();
    repeat (4) send_frame(3, -1);
    tx_end();
    check_rx(4, 1'b0);
    chk_reg(gapq.size(), 3);
    foreach (gapq[k]) chk_reg(gapq[k], 1);
    apb(`TGM_A_CFG, 1'b1, 32'h13);
    gapq.delete();
    repeat (4) send_frame(3, -1);
    tx_end();
    check_rx(4, 1'b0);
    chk_reg(gapq.size(), 3);
    for (i = 0; i < 2; i++) chk_reg(gapq[i] + gapq[i + 1], 1);
    for (i = 0; i < 3; i++) begin
      apb(`TGM_A_CFG, 1'b1, cfg_v[i]);
      clk_locked <= (i != 2);
      probe_tready();
    end
    apb(`TGM_A_STAT, 1'b0, 32'h0);
    chk_reg(rd, 32'h0);
    clk_locked <= 1'b1;
    apb(`TGM_A_CFG, 1'b1, 32'h1);
    send_frame(4, -1);
    tx_end();
    check_rx(0, 1'b0);
    apb(`TGM_A_CFG, 1'b1, `TGM_CFG_RST);
    inject_local <= 1'b1;
    repeat (20) @(posedge pclk);
    apb(`TGM_A_STAT, 1'b0, 32'h0);
    chk_reg(rd, 32'h5);
    send_frame(4, -1);
    tx_end();
    check_rx(0, 1'b0);
    inject_local  <= 1'b0;
    inject_remote <= 1'b1;
    repeat (150) @(posedge pclk);
    apb(`TGM_A_STAT, 1'b0, 32'h0);
    chk_reg(rd, 32'h6);
    inject_remote <= 1'b0;
    repeat (150) @(posedge pclk);
    apb(`TGM_A_STAT, 1'b0, 32'h0);
    chk_reg(rd, 32'h4);
    apb(`TGM_A_DIV, 1'b1, 32'h1);
    mdio({5'h0, 1'b1, phyad, 5'h0, 16'h0});
    chk_reg(rd, {16'h0, `TGM_PHY_RST});
    for (i = 1; i < 4; i++) begin
      d = 16'($random(seed));
      mdio({5'h0, 1'b0, phyad, 5'(i), d});
      mdio({5'h0, 1'b1, phyad, 5'(i), 16'h0});
      chk_reg(rd, {16'h0, d});
    end
    mdio({5'h0, 1'b1, phyad ^ 5'h1, 5'h1, 16'h0});
    chk_reg(rd, 32'h0000ffff);
    stop_test();
  end
endmodule : tb_ten_gig_mac_fault_and_mgmt

`default_nettype wire

// *** verification/tgm_link_monitor.sv ***
// Checker for the media link between the MAC end and the PHY end
`timescale 1ns/1ns
`default_nettype none
`include "tgm_defs.svh"

module tgm_link_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [63:0] txd,
  input wire logic [7:0]  txc,
  input wire logic [63:0] rxd,
  input wire logic [7:0]  rxc,
  input wire logic        mdc,
  input wire logic        mdio_m_oe_n
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic rx_lf;
  logic rx_rf;
  logic tx_rf;
  logic tx_idle;
  logic tx_term;

  // Fault sets decode only the data of lanes 0 to 3, as lanes 4 to 7 repeat it; idle and terminate compare the whole word
  assign rx_lf   = (rxc == `TGM_CTL_SEQ) && (rxd[31:0] == `TGM_LF_SEQ);
  assign rx_rf   = (rxc == `TGM_CTL_SEQ) && (rxd[31:0] == `TGM_RF_SEQ);
  assign tx_rf   = (txc == `TGM_CTL_SEQ) && (txd[31:0] == `TGM_RF_SEQ);
  assign tx_idle = (txc == `TGM_CTL_ALL) && (txd == `TGM_IDLE_WORD);
  assign tx_term = (txc == `TGM_CTL_ALL) && (txd == `TGM_TERM_WORD);

  //--------------------------------------------------------------------
  // Properties
  //--------------------------------------------------------------------
  property p_reset_idle;
    $rose(presetn) |-> tx_idle && !mdc && mdio_m_oe_n;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("link not idle after reset");

  property p_mdc_high;
    $rose(mdc) |-> mdc [*2];
  endproperty
  a_mdc_high: assert property (p_mdc_high) else $error("serial clock high too short");

  property p_mdc_low;
    $fell(mdc) |-> !mdc [*2];
  endproperty
  a_mdc_low: assert property (p_mdc_low) else $error("serial clock low too short");

  property p_lf_to_rf;
    rx_lf [*8] |-> tx_rf;
  endproperty
  a_lf_to_rf: assert property (p_lf_to_rf) else $error("no remote sets under local fault");

  property p_rf_to_idle;
    rx_rf [*8] |-> tx_idle;
  endproperty
  a_rf_to_idle: assert property (p_rf_to_idle) else $error("no idles under remote fault");

  property p_no_data_in_fault;
    (rx_lf || rx_rf) [*8] |-> txc != `TGM_CTL_NONE;
  endproperty
  a_no_data_in_fault: assert property (p_no_data_in_fault) else $error("data sent in fault");

  property p_access_clocked;
    $fell(mdio_m_oe_n) |-> ##[1:600] $changed(mdc);
  endproperty
  a_access_clocked: assert property (p_access_clocked) else $error("serial drive without clock");

  property p_term_next;
    tx_term |=> tx_idle || txc == `TGM_CTL_START || txc == `TGM_CTL_SEQ;
  endproperty
  a_term_next: assert property (p_term_next) else $error("bad word after terminate");
endmodule : tgm_link_monitor

`default_nettype wire
